// ---- adcs_top.v ----
// converter control sequencer with apb register access
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defs.vh"

module adcs_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [3:0]  pb_in,
  input  wire [3:0]  pullup_opt,
  output wire [3:0]  pb_out,
  output wire [3:0]  pb_oen_n,
  output wire [3:0]  pb_pullup_en,
  output wire [3:0]  ana_sel,
  input  wire [8:0]  conv_data,
  output wire        conv_clk_en,
  output wire        conv_reset,
  output wire        conv_power,
  output wire [1:0]  conv_chan,
  output wire        adc_irq
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_HOLD = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  // software state
  reg        start_q;
  reg [2:0]  pcr_q;
  reg [1:0]  acs_q;
  reg [1:0]  div_q;
  reg        nine_q;
  reg        gie_q;
  reg        cie_q;
  reg        irqf_q;
  reg [3:0]  dir_q;
  reg [3:0]  data_q;
  reg [7:0]  res_lo_q;
  reg [7:0]  res_hi_q;

  // sequencer state
  reg [1:0]  state_q;
  reg [6:0]  cnt_q;
  reg        eoc_q;
  reg        conv_reset_q;
  reg        conv_power_q;
  reg [1:0]  conv_chan_q;
  reg        irq_q;

  // bus answer
  reg [31:0] prdata_q;
  reg        pready_q;
  reg        pslverr_q;
  reg [31:0] rd_d;
  reg        hit_d;

  wire       setup_ph;
  wire       wr_en;
  wire       wr_ctrl;
  wire       wr_clk;
  wire       wr_irqc;
  wire       wr_dir;
  wire       wr_data;
  wire       new_start;
  wire       start_rise;
  wire       start_fall;
  wire       tick;
  wire       finish;
  wire [6:0] conv_len;
  wire [3:0] ana_mask;

  // bus phases; writes land in the access cycle that pready closes
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pready_q & pwrite;
  assign wr_ctrl  = wr_en && (paddr == `ADCS_OFS_CTRL);
  assign wr_clk   = wr_en && (paddr == `ADCS_OFS_CLK);
  assign wr_irqc  = wr_en && (paddr == `ADCS_OFS_IRQC);
  assign wr_dir   = wr_en && (paddr == `ADCS_OFS_DIR);
  assign wr_data  = wr_en && (paddr == `ADCS_OFS_DATA);

  // start bit edges as seen by software writes
  assign new_start  = pwdata[`ADCS_CTRL_START];
  assign start_rise = wr_ctrl & new_start & ~start_q;
  assign start_fall = wr_ctrl & ~new_start & start_q;

  // conversion length per resolution variant
  assign conv_len = nine_q ? `ADCS_LEN9 : `ADCS_LEN8;
  assign finish   = (state_q == ST_CONV) & tick & (cnt_q == conv_len - 7'h01);

  // pin function decode: codes 1..3 take the low pins, 4 up all four
  function [3:0] pcr_decode;
    input [2:0] code;
    begin
      case (code)
        3'h0: pcr_decode = 4'h0;
        3'h1: pcr_decode = 4'h1;
        3'h2: pcr_decode = 4'h3;
        3'h3: pcr_decode = 4'h7;
        default: pcr_decode = 4'hF;
      endcase
    end
  endfunction

  assign ana_mask = pcr_decode(pcr_q);

  // converter clock enable, realigned at the start falling edge
  adcs_clkdiv u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (start_fall),
    .div_sel (div_q),
    .tick    (tick)
  );

  // shared pins, each switched between digital and analog use
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      adcs_pin u_pin (
        .pclk       (pclk),
        .presetn    (presetn),
        .analog_en  (ana_mask[gi]),
        .dir_in     (dir_q[gi]),
        .out_data   (data_q[gi]),
        .pullup_opt (pullup_opt[gi]),
        .pin_out    (pb_out[gi]),
        .pin_oen_n  (pb_oen_n[gi]),
        .pullup_en  (pb_pullup_en[gi]),
        .ana_sel    (ana_sel[gi])
      );
    end
  endgenerate

  // control, clock and port registers written by software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      pcr_q   <= `ADCS_RST_CTRL_PCR;
      acs_q   <= `ADCS_RST_CTRL_ACS;
      div_q   <= `ADCS_RST_DIV;
      nine_q  <= `ADCS_RST_NINE;
      gie_q   <= 1'b0;
      cie_q   <= 1'b0;
      dir_q   <= `ADCS_RST_DIR;
      data_q  <= `ADCS_RST_DATA;
    end else begin
      if (wr_ctrl) begin
        start_q <= new_start;
        pcr_q   <= pwdata[`ADCS_PCR_HI:`ADCS_PCR_LO];
        // top channel bit is held at zero
        acs_q   <= pwdata[`ADCS_ACS_HI-1:`ADCS_ACS_LO];
      end
      if (wr_clk) begin
        div_q  <= pwdata[`ADCS_CLK_DIV_HI:`ADCS_CLK_DIV_LO];
        nine_q <= pwdata[`ADCS_CLK_NINE];
      end
      if (wr_irqc) begin
        gie_q <= pwdata[`ADCS_IRQC_GIE];
        cie_q <= pwdata[`ADCS_IRQC_CIE];
      end
      if (wr_dir)
        dir_q <= pwdata[3:0];
      if (wr_data)
        data_q <= pwdata[3:0];
    end
  end

  // sequencer: hold in reset while start is high, count after it falls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= ST_IDLE;
      cnt_q        <= 7'h00;
      eoc_q        <= 1'b1;
      conv_reset_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_rise) begin
            state_q      <= ST_HOLD;
            eoc_q        <= 1'b1;
            conv_reset_q <= 1'b1;
          end
        end
        ST_HOLD: begin
          eoc_q        <= 1'b1;
          conv_reset_q <= 1'b1;
          if (start_fall) begin
            cnt_q        <= 7'h00;
            conv_reset_q <= 1'b0;
            // the field written with the fall decides; a powered-down converter does not run
            if (pwdata[`ADCS_PCR_HI:`ADCS_PCR_LO] != 3'h0)
              state_q <= ST_CONV;
            else
              state_q <= ST_IDLE;
          end
        end
        ST_CONV: begin
          if (start_rise) begin
            state_q      <= ST_HOLD;
            eoc_q        <= 1'b1;
            conv_reset_q <= 1'b1;
          end else if (finish) begin
            state_q <= ST_IDLE;
            eoc_q   <= 1'b0;
          end else if (tick) begin
            cnt_q <= cnt_q + 7'h01;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // result bytes load only on completion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_lo_q <= 8'h00;
      res_hi_q <= 8'h00;
    end else if (finish && !start_rise) begin
      if (nine_q) begin
        res_hi_q <= conv_data[8:1];
        res_lo_q <= {conv_data[0], 7'h00};
      end else begin
        res_hi_q <= conv_data[7:0];
        res_lo_q <= 8'h00;
      end
    end
  end

  // request flag: completion wins over a software clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqf_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      if (finish && !start_rise)
        irqf_q <= 1'b1;
      else if (wr_irqc)
        irqf_q <= pwdata[`ADCS_IRQC_FLAG];
      irq_q <= irqf_q & gie_q & cie_q;
    end
  end

  // converter side outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_power_q <= 1'b0;
      conv_chan_q  <= 2'h0;
    end else begin
      conv_power_q <= (pcr_q != 3'h0);
      conv_chan_q  <= acs_q;
    end
  end

  // read mux; unmapped addresses answer with an error
  always @* begin
    rd_d  = 32'h0000_0000;
    hit_d = 1'b1;
    if (paddr == `ADCS_OFS_CTRL) begin
      rd_d[`ADCS_CTRL_START]          = start_q;
      rd_d[`ADCS_CTRL_EOC]            = eoc_q;
      rd_d[`ADCS_PCR_HI:`ADCS_PCR_LO] = pcr_q;
      rd_d[`ADCS_ACS_HI:`ADCS_ACS_LO] = {1'b0, acs_q};
    end else if (paddr == `ADCS_OFS_CLK) begin
      rd_d[`ADCS_CLK_DIV_HI:`ADCS_CLK_DIV_LO] = div_q;
      rd_d[`ADCS_CLK_NINE]                     = nine_q;
    end else if (paddr == `ADCS_OFS_IRQC) begin
      rd_d[`ADCS_IRQC_GIE]  = gie_q;
      rd_d[`ADCS_IRQC_CIE]  = cie_q;
      rd_d[`ADCS_IRQC_FLAG] = irqf_q;
    end else if (paddr == `ADCS_OFS_RESLO) begin
      rd_d[7:0] = res_lo_q;
    end else if (paddr == `ADCS_OFS_RESHI) begin
      rd_d[7:0] = res_hi_q;
    end else if (paddr == `ADCS_OFS_DIR) begin
      rd_d[3:0] = dir_q;
    end else if (paddr == `ADCS_OFS_DATA) begin
      rd_d[3:0] = pb_in;
    end else begin
      hit_d = 1'b0;
    end
  end

  // answer in the first access cycle; conversion never holds the bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & ~hit_d;
      if (setup_ph && !pwrite)
        prdata_q <= rd_d;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign conv_clk_en = tick;
  assign conv_reset  = conv_reset_q;
  assign conv_power  = conv_power_q;
  assign conv_chan   = conv_chan_q;
  assign adc_irq     = irq_q;

endmodule
`default_nettype wire

// ---- adcs_defs.vh ----
// constants and field layout of the converter control sequencer
// Operation
// - divider codes 00,01,10 give /2,/8,/32
// - pin function field picks digital or analog
// - analog pins lose their pull-up
// - analog enable overrides port direction
// - start pulse leaves conversion flag high
// - start 0 to 1 to 0 begins conversion
// - flag drops low when conversion finishes
// - both enables set give converter interrupt
// - polling the flag needs no interrupt
// - conversion lasts 64 or 76 converter clocks
// - conversion runs without stalling the bus
// - pin field zero: all digital, converter off
// - channel field routes one of four inputs
// - code 100 up: all analog; bit2 zero
// - start held high resets converter, flag high
// - nine-bit result split high and low bytes
// - request flag set at end regardless enable
`ifndef ADCS_DEFS_VH
`define ADCS_DEFS_VH

// register byte offsets
`define ADCS_OFS_CTRL   8'h00
`define ADCS_OFS_CLK    8'h04
`define ADCS_OFS_IRQC   8'h08
`define ADCS_OFS_RESLO  8'h0C
`define ADCS_OFS_RESHI  8'h10
`define ADCS_OFS_DIR    8'h14
`define ADCS_OFS_DATA   8'h18

// converter_control_reg fields
`define ADCS_CTRL_START 7
`define ADCS_CTRL_EOC   6
`define ADCS_PCR_HI     5
`define ADCS_PCR_LO     3
`define ADCS_ACS_HI     2
`define ADCS_ACS_LO     0

// converter_clock_reg fields
`define ADCS_CLK_DIV_HI 1
`define ADCS_CLK_DIV_LO 0
`define ADCS_CLK_NINE   7

// interrupt_control_reg fields
`define ADCS_IRQC_GIE   0
`define ADCS_IRQC_CIE   1
`define ADCS_IRQC_FLAG  2

// reset values
`define ADCS_RST_CTRL_PCR 3'h0
`define ADCS_RST_CTRL_ACS 2'h0
`define ADCS_RST_DIV      2'h0
`define ADCS_RST_NINE     1'b1
`define ADCS_RST_DIR      4'hF
`define ADCS_RST_DATA     4'h0

// divider terminal counts (period minus one)
`define ADCS_DIV2_TERM  5'h01
`define ADCS_DIV8_TERM  5'h07
`define ADCS_DIV32_TERM 5'h1F

// conversion length in converter clock periods
`define ADCS_LEN8       7'h40
`define ADCS_LEN9       7'h4C

`endif

// ---- adcs_clkdiv.v ----
// converter clock divider producing a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defs.vh"

module adcs_clkdiv (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       restart,
  input  wire [1:0] div_sel,
  output wire       tick
);

  reg [4:0] cnt_q;
  reg       tick_q;
  reg [4:0] term;
  reg       valid;

  // terminal count per divider code; code 11 has no clock
  always @* begin
    term  = `ADCS_DIV2_TERM;
    valid = 1'b1;
    case (div_sel)
      2'h0: term = `ADCS_DIV2_TERM;
      2'h1: term = `ADCS_DIV8_TERM;
      2'h2: term = `ADCS_DIV32_TERM;
      default: valid = 1'b0;
    endcase
  end

  // free-running count, restarted to align with a conversion start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 5'h00;
      tick_q <= 1'b0;
    end else if (restart || !valid) begin
      cnt_q  <= 5'h00;
      tick_q <= 1'b0;
    end else if (cnt_q == term) begin
      cnt_q  <= 5'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 5'h01;
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;

endmodule
`default_nettype wire

// ---- adcs_pin.v ----
// one shared port pin: digital i/o or analog input
`timescale 1ns/1ps
`default_nettype none

module adcs_pin (
  input  wire pclk,
  input  wire presetn,
  input  wire analog_en,
  input  wire dir_in,
  input  wire out_data,
  input  wire pullup_opt,
  output wire pin_out,
  output wire pin_oen_n,
  output wire pullup_en,
  output wire ana_sel
);

  reg pin_out_q;
  reg pin_oen_n_q;
  reg pullup_en_q;
  reg ana_sel_q;

  // analog use overrides direction and drops the pull-up
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q   <= 1'b0;
      pin_oen_n_q <= 1'b1;
      pullup_en_q <= 1'b0;
      ana_sel_q   <= 1'b0;
    end else begin
      pin_out_q   <= out_data & ~analog_en;
      pin_oen_n_q <= analog_en | dir_in;
      pullup_en_q <= pullup_opt & ~analog_en;
      ana_sel_q   <= analog_en;
    end
  end

  assign pin_out   = pin_out_q;
  assign pin_oen_n = pin_oen_n_q;
  assign pullup_en = pullup_en_q;
  assign ana_sel   = ana_sel_q;

endmodule
`default_nettype wire

// ---- adcs_properties.sv ----
// port checker for the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module adcs_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  pb_in,
  input wire logic [3:0]  pullup_opt,
  input wire logic [3:0]  pb_out,
  input wire logic [3:0]  pb_oen_n,
  input wire logic [3:0]  pb_pullup_en,
  input wire logic [3:0]  ana_sel,
  input wire logic [8:0]  conv_data,
  input wire logic        conv_clk_en,
  input wire logic        conv_reset,
  input wire logic        conv_power,
  input wire logic [1:0]  conv_chan,
  input wire logic        adc_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // completed write to the control register
  wire wr_ctrl = psel && penable && pwrite && (paddr == 8'h00);

  a_ready_after_setup:
    assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_pullup_cut:
    assert property ((pb_pullup_en & ana_sel) == 4'h0) else $error("pull-up on analog pin");
  a_analog_no_drive:
    assert property ((ana_sel & ~pb_oen_n) == 4'h0) else $error("analog pin driven");
  a_pin_codes:
    assert property (ana_sel inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
      else $error("illegal analog pin set");
  a_power_idle:
    assert property (conv_power == (ana_sel != 4'h0)) else $error("power and pins disagree");
  a_tick_single:
    assert property (conv_clk_en |=> !conv_clk_en) else $error("converter tick too long");
  a_chan_on_write:
    assert property (!$stable(conv_chan) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
      else $error("channel moved without write");
  a_pins_on_write:
    assert property (!$stable(ana_sel) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
      else $error("pin function moved without write");

  // main scenarios
  c_irq: cover property ($rose(adc_irq));
  c_err: cover property (pslverr);
  c_all: cover property (ana_sel == 4'hF);
endmodule

bind adcs_top adcs_properties adcs_properties_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .pb_in, .pullup_opt, .pb_out, .pb_oen_n, .pb_pullup_en, .ana_sel,
  .conv_data, .conv_clk_en, .conv_reset, .conv_power, .conv_chan, .adc_irq
);
`default_nettype wire

// ---- tb_adcs_top.sv ----
// self-checking testbench for the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_adcs_top;
  logic        pclk, presetn, psel, penable, pwrite, perr;
  logic        pready, pslverr, conv_clk_en, conv_reset, conv_power, adc_irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pb_in, pullup_opt, pb_out, pb_oen_n, pb_pullup_en, ana_sel;
  logic [8:0]  conv_data;
  logic [1:0]  conv_chan;
  logic [3:0]  amap [8] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'hF, 4'hF, 4'hF};
  logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [7:0]  rv [6] = '{8'h40, 8'h80, 8'h00, 8'h00, 8'h00, 8'h0F};
  int          num_errors, compares, cyc, ticks, t0;

  adcs_top adcs_top_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pb_in, .pullup_opt, .pb_out, .pb_oen_n, .pb_pullup_en, .ana_sel,
    .conv_data, .conv_clk_en, .conv_reset, .conv_power, .conv_chan, .adc_irq
  );

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // verdict and end of run
  task automatic finish_test();
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // compare and count
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one apb transfer followed by an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", pready, 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // one conversion, its timing, results and request flag
  task automatic conv(input logic [1:0] dv, input logic nine, input logic [7:0] ctl,
                      input logic [8:0] d);
    int len;
    len = (nine ? 76 : 64) * (2 << (2 * dv));
    conv_data <= d;
    apb(1'b1, 8'h04, {24'h0, nine, 5'h0, dv});
    apb(1'b1, 8'h00, {24'h0, ctl | 8'h80});
    apb(1'b1, 8'h00, {24'h0, ctl});
    repeat (len - 4) @(posedge pclk);
    chk("chan", conv_chan, ctl[1:0]);
    apb(1'b0, 8'h00, 32'h0);
    chk("busy", rd[6], 1'b1);
    repeat (6) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk("done", rd, {24'h0, ctl});
    apb(1'b0, 8'h10, 32'h0);
    chk("res hi", rd, {24'h0, nine ? d[8:1] : d[7:0]});
    apb(1'b0, 8'h0C, 32'h0);
    chk("res lo", rd, {24'h0, nine & d[0], 7'h0});
    apb(1'b0, 8'h08, 32'h0);
    chk("req", rd[2], 1'b1);
  endtask

  // converter clock pulses, counted away from the sampling edge
  always @(negedge pclk) begin
    if (conv_clk_en) begin
      ticks++;
    end
  end

  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pb_in = 4'h9;
    pullup_opt = 4'hB;
    conv_data = 9'h000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped slot, pin inputs
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset", rd, {24'h0, rv[i]});
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", perr, 1'b1);
    chk("unmapped", rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("pins in", rd, 32'h9);
    // every pin function code with all pins set to drive
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h18, 32'hF);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 8'h00, c << 3);
      @(posedge pclk);
      chk("analog", ana_sel, amap[c]);
      chk("pullup", pb_pullup_en, pullup_opt & ~amap[c]);
      chk("oen", pb_oen_n, amap[c]);
      chk("power", conv_power, c != 0);
      chk("pin out", pb_out, 4'hF & ~amap[c]);
    end
    // each clocked divider code at nine bits, then eight bits at code 01
    for (int v = 0; v < 3; v++) begin
      conv(v[1:0], 1'b1, 8'h21, 9'h1A5);
    end
    conv(2'h1, 1'b0, 8'h23, 9'h05A);
    conv_data <= 9'h000;
    apb(1'b0, 8'h10, 32'h0);
    chk("res hold", rd, 32'h5A);
    // interrupt needs request flag and both enables
    chk("irq off", adc_irq, 1'b0);
    apb(1'b1, 8'h08, 32'h5);
    @(posedge pclk);
    chk("irq half", adc_irq, 1'b0);
    apb(1'b1, 8'h08, 32'h7);
    @(posedge pclk);
    chk("irq on", adc_irq, 1'b1);
    apb(1'b1, 8'h08, 32'h3);
    @(posedge pclk);
    chk("irq clr", adc_irq, 1'b0);
    conv(2'h0, 1'b1, 8'h3A, 9'h101);
    chk("irq conv", adc_irq, 1'b1);
    // abort mid-run, then start held high
    apb(1'b1, 8'h00, 32'hA1);
    apb(1'b1, 8'h00, 32'h21);
    repeat (50) @(posedge pclk);
    apb(1'b1, 8'h00, 32'hA1);
    repeat (300) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk("held", rd, 32'hE1);
    chk("conv rst", conv_reset, 1'b1);
    // start pulse with no analog pin stays idle
    apb(1'b1, 8'h00, 32'h0);
    repeat (300) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk("idle", rd, 32'h40);
    chk("off", conv_power, 1'b0);
    // divide by two gives a pulse every other cycle, code 11 none
    t0 = ticks;
    repeat (100) @(posedge pclk);
    chk("ticks div2", ticks - t0, 50);
    apb(1'b1, 8'h04, 32'h83);
    t0 = ticks;
    repeat (100) @(posedge pclk);
    chk("ticks none", ticks - t0, 0);
    finish_test();
  end
endmodule
`default_nettype wire
